// ==== pkg/utxf_pkg.sv ====
// Package for the serial transmitter: format, states, carriers, constants
package utxf_pkg;

   localparam logic [15:0] UTXF_DIV_RESET = 16'h0000;
   localparam logic [2:0] UTXF_FRAC_RESET = 3'h0;
   localparam logic [3:0] UTXF_ACC_RESET = 4'h0;
   localparam logic [4:0] UTXF_BREAK_BITS = 5'h0d;
   localparam logic [1:0] UTXF_STOP_BITS = 2'h2;
   localparam logic [3:0] UTXF_WORD8_BITS = 4'h8;
   localparam logic [3:0] UTXF_WORD9_BITS = 4'h9;
   localparam int UTXF_ACC_CARRY_POS = 3;

   localparam logic [1:0] UTXF_PAR_EVEN = 2'h0;
   localparam logic [1:0] UTXF_PAR_ODD = 2'h1;
   localparam logic [1:0] UTXF_PAR_MARK = 2'h2;
   localparam logic [1:0] UTXF_PAR_SPACE = 2'h3;

   typedef enum logic [2:0] {
      UTXF_IDLE = 3'b000,
      UTXF_START = 3'b001,
      UTXF_DATA = 3'b010,
      UTXF_STOP = 3'b011,
      UTXF_BRK = 3'b100
   } utxf_state_t;

   // Shared frame format, also used by the receiver side
   typedef struct packed {
      logic word_length_select;
      logic parity_enable_bit;
      logic [1:0] parity_type_field;
      logic rx_stop_count_select;
      logic tx_ninth_bit;
      logic addr_detect_en;
   } utxf_fmt_t;

   typedef struct packed {
      logic [15:0] baud_divider_value;
      logic [2:0] baud_fraction_steps;
   } utxf_baud_t;

   typedef struct packed {
      logic valid;
      logic [8:0] word;
   } utxf_slot_t;

   typedef struct packed {
      utxf_state_t state;
      logic [15:0] div_cnt;
      logic [3:0] mod_acc;
      logic [8:0] tx_shift_register;
      logic [3:0] bits_left;
      logic [4:0] brk_cnt;
      logic brk_frame;
      utxf_slot_t slot0;
      utxf_slot_t slot1;
      logic status_read;
      logic tx_empty_flag;
      logic tx_idle_flag;
      logic tx_irq;
      logic serial_out_pin;
      logic serial_out_oe;
      logic line_in_en;
      logic rx_idle_flag;
      logic wr_ready;
   } utxf_regs_t;

endpackage : utxf_pkg

// ==== rtl/utxf_uart_tx.sv ====
// Serial transmitter with fractional baud generator and two-entry buffer
// How it works
// - Add fraction per bit; carry adds cycle
// - Base bit period is 16-bit divider
// - NRZ frame, start, data LSB first
// - Even, odd, mark, space or none parity
// - Address flag occupies word MSB
// - Reset format: 8 bits, no parity
// - Transmitter always sends two stop bits
// - Receiver shares format and baud settings
// - Module and transmit enables drive output; module and receive, line input
// - Output line high when not shifting
// - Disable releases pins, empties buffer
// - Disable clears flags, sets empty, idle
// - Disable aborts; re-enable keeps configuration
// - Nine-bit mode MSB from ninth bit
// - Reload shift register only after rx_stop_count_select
// - Start needs transmit enable and word
// - Clearing transmit enable rx_stop_count_select, resets transmitter
// - Writes ignored while empty flag low
// - Empty flag when buffer accepts; irq
// - Write during frame waits in buffer
// - Write while idle goes straight out
// - Idle flag set after frame completes
// - Break: start, thirteen zeros, two rx_stop_count_select
`timescale 1ns/1ns
module utxf_uart_tx
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic serial_module_enable,
   input wire logic transmit_enable_bit,
   input wire logic receive_enable_bit,
   input wire logic send_break_bit,
   input wire logic tx_empty_irq_enable,
   input wire utxf_pkg::utxf_fmt_t fmt,
   input wire utxf_pkg::utxf_baud_t baud,
   input wire logic status_read,
   input wire logic data_write,
   input wire logic [7:0] serial_data_buffer,
   output logic wr_ready,
   output logic serial_out_pin,
   output logic serial_out_oe,
   output logic line_in_en,
   output logic tx_empty_flag,
   output logic tx_idle_flag,
   output logic rx_idle_flag,
   output logic tx_irq,
   output logic [3:0] mod_acc_out
);

   utxf_pkg::utxf_regs_t r_q;
   utxf_pkg::utxf_regs_t r_d;

   // Parity over the low data bits, even/odd/mark/space
   function automatic logic par_bit(input logic [8:0] w, input logic nine,
                                    input logic [1:0] ty);
      logic x;
      x = nine ? ^w[7:0] : ^w[6:0];
      case (ty)
         utxf_pkg::UTXF_PAR_EVEN: par_bit = x;
         utxf_pkg::UTXF_PAR_ODD: par_bit = ~x;
         utxf_pkg::UTXF_PAR_MARK: par_bit = 1'b1;
         default: par_bit = 1'b0;
      endcase
   endfunction : par_bit

   // Assemble the word with MSB as ninth bit, parity or address flag
   function automatic logic [8:0] build_word(input logic [7:0] d,
                                             input utxf_pkg::utxf_fmt_t f);
      logic [8:0] w;
      w = {1'b0, d};
      if (f.word_length_select)
         w[8] = f.tx_ninth_bit;
      if (f.parity_enable_bit)
      begin
         if (f.word_length_select)
            w[8] = par_bit(w, 1'b1, f.parity_type_field);
         else
            w[7] = par_bit(w, 1'b0, f.parity_type_field);
      end
      else if (f.addr_detect_en)
      begin
         if (f.word_length_select)
            w[8] = f.tx_ninth_bit;
         else
            w[7] = d[7];
      end
      build_word = w;
   endfunction : build_word

   // Bit time for the current bit; fraction carry adds one cycle
   function automatic logic [16:0] bit_len(input logic [3:0] acc,
                                           input logic [2:0] fr,
                                           input logic [15:0] dv);
      logic [4:0] s;
      s = {1'b0, acc} + {2'b00, fr};
      bit_len = {1'b0, dv} + {16'h0000, s[4] | s[utxf_pkg::UTXF_ACC_CARRY_POS]
                & ~acc[utxf_pkg::UTXF_ACC_CARRY_POS]};
   endfunction : bit_len

   logic tx_on;
   logic [4:0] acc_sum;
   logic bit_end;
   logic [16:0] blen;
   logic [8:0] head_word;
   logic wr_ok;

   always_comb
   begin
      r_d = r_q;
      tx_on = serial_module_enable & transmit_enable_bit;
      acc_sum = {1'b0, r_q.mod_acc} + {2'b00, baud.baud_fraction_steps};
      blen = bit_len(r_q.mod_acc, baud.baud_fraction_steps,
                     baud.baud_divider_value);
      bit_end = ({1'b0, r_q.div_cnt} + 17'h00001) >= blen;
      head_word = r_q.slot0.word;
      wr_ok = data_write & r_q.status_read & r_q.tx_empty_flag;

      if (status_read)
         r_d.status_read = 1'b1;

      // Buffer write; its clear of status_read overrides a status read in the same cycle
      if (wr_ok)
      begin
         r_d.status_read = 1'b0;
         if (!r_q.slot0.valid)
         begin
            r_d.slot0.valid = 1'b1;
            r_d.slot0.word = build_word(serial_data_buffer, fmt);
         end
         else
         begin
            r_d.slot1.valid = 1'b1;
            r_d.slot1.word = build_word(serial_data_buffer, fmt);
         end
         r_d.tx_idle_flag = 1'b0;
      end

      // Divider runs every cycle while a frame is active
      if (r_q.state != utxf_pkg::UTXF_IDLE)
         r_d.div_cnt = bit_end ? utxf_pkg::UTXF_DIV_RESET
                               : r_q.div_cnt + 16'h0001;
      if (r_q.state != utxf_pkg::UTXF_IDLE && bit_end)
         r_d.mod_acc = acc_sum[3:0];

      case (r_q.state)
         utxf_pkg::UTXF_IDLE:
         begin
            r_d.serial_out_pin = 1'b1;
            if (tx_on && send_break_bit && r_q.tx_idle_flag)
            begin
               r_d.state = utxf_pkg::UTXF_START;
               r_d.brk_frame = 1'b1;
               r_d.brk_cnt = utxf_pkg::UTXF_BREAK_BITS;
               r_d.div_cnt = utxf_pkg::UTXF_DIV_RESET;
               r_d.mod_acc = utxf_pkg::UTXF_ACC_RESET;
               r_d.serial_out_pin = 1'b0;
               r_d.tx_idle_flag = 1'b0;
            end
            else if (tx_on && r_q.slot0.valid)
            begin
               r_d.state = utxf_pkg::UTXF_START;
               r_d.brk_frame = 1'b0;
               r_d.tx_shift_register = head_word;
               // A word written in this cycle sits in slot1; keep it
               r_d.slot0 = wr_ok ? r_d.slot1 : r_q.slot1;
               r_d.slot1.valid = 1'b0;
               r_d.bits_left = fmt.word_length_select ?
                  utxf_pkg::UTXF_WORD9_BITS : utxf_pkg::UTXF_WORD8_BITS;
               r_d.div_cnt = utxf_pkg::UTXF_DIV_RESET;
               r_d.mod_acc = utxf_pkg::UTXF_ACC_RESET;
               r_d.serial_out_pin = 1'b0;
               r_d.tx_idle_flag = 1'b0;
            end
         end
         utxf_pkg::UTXF_START:
            if (bit_end)
            begin
               if (r_q.brk_frame)
               begin
                  r_d.state = utxf_pkg::UTXF_BRK;
                  r_d.serial_out_pin = 1'b0;
               end
               else
               begin
                  r_d.state = utxf_pkg::UTXF_DATA;
                  r_d.serial_out_pin = r_q.tx_shift_register[0];
               end
            end
         utxf_pkg::UTXF_DATA:
            if (bit_end)
            begin
               r_d.tx_shift_register = {1'b1, r_q.tx_shift_register[8:1]};
               r_d.bits_left = r_q.bits_left - 4'h1;
               if (r_q.bits_left == 4'h1)
               begin
                  r_d.state = utxf_pkg::UTXF_STOP;
                  r_d.bits_left = {2'b00, utxf_pkg::UTXF_STOP_BITS};
                  r_d.serial_out_pin = 1'b1;
               end
               else
                  r_d.serial_out_pin = r_q.tx_shift_register[1];
            end
         utxf_pkg::UTXF_BRK:
            if (bit_end)
            begin
               r_d.brk_cnt = r_q.brk_cnt - 5'h01;
               if (r_q.brk_cnt == 5'h01)
               begin
                  if (send_break_bit)
                     r_d.brk_cnt = utxf_pkg::UTXF_BREAK_BITS;
                  else
                  begin
                     r_d.state = utxf_pkg::UTXF_STOP;
                     r_d.bits_left = {2'b00, utxf_pkg::UTXF_STOP_BITS};
                     r_d.serial_out_pin = 1'b1;
                  end
               end
            end
         utxf_pkg::UTXF_STOP:
            if (bit_end)
            begin
               r_d.bits_left = r_q.bits_left - 4'h1;
               if (r_q.bits_left == 4'h1)
               begin
                  r_d.state = utxf_pkg::UTXF_IDLE;
                  r_d.tx_idle_flag = ~r_q.slot0.valid | r_q.brk_frame;
                  r_d.brk_frame = 1'b0;
               end
            end
         default:
            r_d.state = utxf_pkg::UTXF_IDLE;
      endcase

      // Empty while at least one buffer slot is free
      r_d.tx_empty_flag = ~r_d.slot1.valid;
      r_d.tx_irq = r_d.tx_empty_flag & tx_empty_irq_enable;
      r_d.serial_out_oe = tx_on;
      r_d.line_in_en = serial_module_enable & receive_enable_bit;
      r_d.wr_ready = r_d.tx_empty_flag;

      // Transmit disable aborts the frame but keeps buffered data
      if (!transmit_enable_bit && r_q.state != utxf_pkg::UTXF_IDLE)
      begin
         r_d.state = utxf_pkg::UTXF_IDLE;
         r_d.serial_out_pin = 1'b1;
         r_d.brk_frame = 1'b0;
         r_d.tx_idle_flag = 1'b1;
      end

      if (!serial_module_enable)
      begin
         r_d.state = utxf_pkg::UTXF_IDLE;
         r_d.slot0.valid = 1'b0;
         r_d.slot1.valid = 1'b0;
         r_d.tx_empty_flag = 1'b1;
         r_d.tx_idle_flag = 1'b1;
         r_d.rx_idle_flag = 1'b1;
         r_d.tx_irq = tx_empty_irq_enable;
         r_d.serial_out_pin = 1'b1;
         r_d.serial_out_oe = 1'b0;
         r_d.line_in_en = 1'b0;
         r_d.brk_frame = 1'b0;
         r_d.status_read = 1'b0;
         r_d.wr_ready = 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         r_q <= '0;
         r_q.state <= utxf_pkg::UTXF_IDLE;
         r_q.tx_empty_flag <= 1'b1;
         r_q.tx_idle_flag <= 1'b1;
         r_q.rx_idle_flag <= 1'b1;
         r_q.serial_out_pin <= 1'b1;
         r_q.wr_ready <= 1'b1;
      end
      else
         r_q <= r_d;
   end

   assign wr_ready = r_q.wr_ready;
   assign serial_out_pin = r_q.serial_out_pin;
   assign serial_out_oe = r_q.serial_out_oe;
   assign line_in_en = r_q.line_in_en;
   assign tx_empty_flag = r_q.tx_empty_flag;
   assign tx_idle_flag = r_q.tx_idle_flag;
   assign rx_idle_flag = r_q.rx_idle_flag;
   assign tx_irq = r_q.tx_irq;
   assign mod_acc_out = r_q.mod_acc;

   a_idle_line_high: assert property (
      @(posedge mclk) disable iff (reset)
      r_q.state == utxf_pkg::UTXF_IDLE |-> serial_out_pin)
      else $error("line not high while idle");

   a_start_bit_low: assert property (
      @(posedge mclk) disable iff (reset)
      $rose(r_q.state == utxf_pkg::UTXF_START) |-> !serial_out_pin)
      else $error("start bit not low");

   a_start_acc_zero: assert property (
      @(posedge mclk) disable iff (reset)
      $rose(r_q.state == utxf_pkg::UTXF_START) |-> r_q.mod_acc == 4'h0)
      else $error("accumulator not cleared at start");

   a_disable_flags: assert property (
      @(posedge mclk) disable iff (reset)
      !serial_module_enable |=> tx_empty_flag && tx_idle_flag
         && rx_idle_flag && !serial_out_oe)
      else $error("disable did not reset flags");

   a_disable_abort: assert property (
      @(posedge mclk) disable iff (reset)
      !serial_module_enable |=> r_q.state == utxf_pkg::UTXF_IDLE
         && !r_q.slot0.valid)
      else $error("disable did not abort");

   a_transmit_enable_bit_abort: assert property (
      @(posedge mclk) disable iff (reset)
      !transmit_enable_bit |=> r_q.state == utxf_pkg::UTXF_IDLE)
      else $error("transmit disable did not stop");

   // Only mid-frame: a frame start may legally move slot1 forward
   a_write_ignored: assert property (
      @(posedge mclk) disable iff (reset)
      data_write && !tx_empty_flag && serial_module_enable
         && r_q.state != utxf_pkg::UTXF_IDLE |=> $stable(r_q.slot1))
      else $error("write accepted while full");

   a_bit_len_base: assert property (
      @(posedge mclk) disable iff (reset)
      r_q.state != utxf_pkg::UTXF_IDLE && $stable(r_q.state)
         && r_q.div_cnt != 16'h0000 |-> r_q.div_cnt
         <= baud.baud_divider_value)
      else $error("divider exceeded bit length");

   a_stop_two: assert property (
      @(posedge mclk) disable iff (reset)
      $rose(r_q.state == utxf_pkg::UTXF_STOP) |-> r_q.bits_left == 4'h2)
      else $error("not two stop bits");

   a_oe_enable: assert property (
      @(posedge mclk) disable iff (reset)
      serial_module_enable && transmit_enable_bit |=> serial_out_oe)
      else $error("output not driven when enabled");

   a_acc_step: assert property (
      @(posedge mclk) disable iff (reset)
      r_q.state != utxf_pkg::UTXF_IDLE && bit_end |=> r_q.mod_acc ==
         4'($past(r_q.mod_acc)
            + {1'b0, $past(baud.baud_fraction_steps)}))
      else $error("accumulator step wrong");

   a_bit_reload: assert property (
      @(posedge mclk) disable iff (reset)
      r_q.state != utxf_pkg::UTXF_IDLE && bit_end
         |=> r_q.div_cnt == 16'h0000)
      else $error("divider not reloaded at bit end");

   a_stop_shift_hold: assert property (
      @(posedge mclk) disable iff (reset)
      r_q.state == utxf_pkg::UTXF_STOP |=> $stable(r_q.tx_shift_register))
      else $error("shift register reloaded before rx_stop_count_select");

   a_break_line_low: assert property (
      @(posedge mclk) disable iff (reset)
      r_q.state == utxf_pkg::UTXF_BRK |-> !serial_out_pin)
      else $error("line not low during break");

   a_idle_after_stop: assert property (
      @(posedge mclk) disable iff (reset)
      r_q.state == utxf_pkg::UTXF_STOP && bit_end && r_q.bits_left == 4'h1
         && !r_q.slot0.valid && !wr_ok && serial_module_enable
         && transmit_enable_bit |=> tx_idle_flag)
      else $error("idle flag not set after frame");

   a_idle_write_empty: assert property (
      @(posedge mclk) disable iff (reset)
      wr_ok && r_q.state == utxf_pkg::UTXF_IDLE && !r_q.slot0.valid
         && serial_module_enable |=> tx_empty_flag)
      else $error("empty flag low after idle write");

endmodule : utxf_uart_tx

// ==== test/utxf_line_rx.sv ====
// Line-side receiver model: samples frames and times every line edge
`timescale 1ns/1ns
module utxf_line_rx
#(
   parameter int DIV = 16
)
(
   input wire logic mclk,
   input wire logic line,
   input wire logic [3:0] nbits
);
   logic [11:0] w;
   logic [11:0] word_q[$];
   int len_q[$];
   int run = 0;
   logic prev = 1'b1;

   // Edge-to-edge lengths, so each bit time is seen on its own
   always @(posedge mclk)
   begin
      if (line !== prev)
      begin
         len_q.push_back(run);
         run = 1;
      end
      else
         run = run + 1;
      prev = line;
   end

   // Mid-bit sampling; no wait after the last sample, so a back-to-back start is caught
   initial
   begin
      forever
      begin
         @(posedge mclk);
         if (line === 1'b0)
         begin
            w = '1;
            repeat (DIV / 2) @(posedge mclk);
            for (int i = 0; i < nbits; i++)
            begin
               w[i] = line;
               if (i + 1 < nbits)
                  repeat (DIV) @(posedge mclk);
            end
            word_q.push_back(w);
         end
      end
   end
endmodule : utxf_line_rx

// ==== test/utxf_uart_tx_bench.sv ====
// Self-checking bench for the serial transmitter
`timescale 1ns/1ns
module utxf_uart_tx_bench;
   localparam int DIV = 16;
   localparam int FR = 3;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic men = 1'b0;
   logic ten = 1'b0;
   logic ren = 1'b0;
   logic brk = 1'b0;
   logic ien = 1'b0;
   logic srd = 1'b0;
   logic dwr = 1'b0;
   logic [7:0] dat = 8'h00;
   logic [3:0] nbits = 4'hb;
   utxf_pkg::utxf_fmt_t fmt = '0;
   utxf_pkg::utxf_baud_t baud = '{16'(DIV), 3'(FR)};
   logic wr_rdy, pin, oe, lin, emp, idl, ridl, irq;
   logic [3:0] acc;
   wire logic line;
   int n_fail = 0;
   int total_checks = 0;
   int cyc = 0;

   always #2 mclk = ~mclk;
   // Released pin is pulled up
   assign line = oe ? pin : 1'b1;

   utxf_uart_tx i_dut (.mclk(mclk), .reset(reset),
      .serial_module_enable(men), .transmit_enable_bit(ten),
      .receive_enable_bit(ren), .send_break_bit(brk),
      .tx_empty_irq_enable(ien), .fmt(fmt), .baud(baud),
      .status_read(srd), .data_write(dwr), .serial_data_buffer(dat),
      .wr_ready(wr_rdy), .serial_out_pin(pin), .serial_out_oe(oe),
      .line_in_en(lin), .tx_empty_flag(emp), .tx_idle_flag(idl),
      .rx_idle_flag(ridl), .tx_irq(irq), .mod_acc_out(acc));

   utxf_line_rx #(.DIV(DIV)) i_model (.mclk(mclk), .line(line),
      .nbits(nbits));

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [15:0] got, input logic [15:0] exp,
      input string msg);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : check

   // Status read first, otherwise the write is dropped
   task automatic send(input logic [7:0] d, output logic ok);
      @(posedge mclk);
      srd <= 1'b1;
      @(posedge mclk);
      srd <= 1'b0;
      dwr <= 1'b1;
      dat <= d;
      @(negedge mclk);
      ok = emp;
      @(posedge mclk);
      dwr <= 1'b0;
   endtask : send

   task automatic wait_idle();
      int n;
      n = 0;
      @(negedge mclk);
      while (idl !== 1'b1 && n < 3000)
      begin
         @(negedge mclk);
         n++;
      end
      check(16'(idl), 16'h1, "idle flag");
   endtask : wait_idle

   task automatic expect_word(input logic [11:0] e);
      int n;
      n = 0;
      while (i_model.word_q.size() == 0 && n < 1000)
      begin
         @(posedge mclk);
         n++;
      end
      if (i_model.word_q.size() == 0)
         check(16'h0, 16'h1, "no frame");
      else
         check({4'h0, i_model.word_q.pop_front()}, {4'h0, e}, "word");
   endtask : expect_word

   function automatic logic [11:0] f8(input logic [7:0] d);
      return {3'h7, d, 1'b0};
   endfunction : f8

   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end

   initial
   begin
      logic ok;
      int a;
      logic [7:0] exp_q[$];
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      @(negedge mclk);
      check({oe, pin, emp, idl, ridl, irq}, 6'b011110, "reset");
      @(posedge mclk);
      men <= 1'b1;
      ren <= 1'b1;
      repeat (3) @(negedge mclk);
      check({lin, oe}, 2'b10, "rx on tx off");
      send(8'h5a, ok);
      repeat (300) @(posedge mclk);
      check(16'(i_model.word_q.size()), 16'h0, "sent while off");
      ten <= 1'b1;
      expect_word(f8(8'h5a));
      @(negedge mclk);
      check(16'(oe), 16'h1, "tx pin driven");
      $display("test format done");
      @(posedge mclk);
      ien <= 1'b1;
      // Two frames: the same lengthened bits must recur in each
      for (int r = 0; r < 2; r++)
      begin
         wait_idle();
         i_model.len_q.delete();
         send(8'h55, ok);
         repeat (4) @(negedge mclk);
         check({idl, emp, irq, wr_rdy}, 4'b0111, "busy flags");
         expect_word(f8(8'h55));
         wait_idle();
         check(16'(acc), 16'((11 * FR) % 16), "accumulator");
         a = 0;
         for (int i = 1; i < 10; i++)
         begin
            check(16'(i_model.len_q[i]), 16'(DIV + ((a % 8) + FR) / 8),
               "bit time");
            a = (a + FR) % 16;
         end
      end
      $display("test modulation done");
      @(posedge mclk);
      ien <= 1'b0;
      for (int t = 0; t < 4; t++)
      begin
         fmt.parity_enable_bit <= 1'b1;
         fmt.parity_type_field <= 2'(t);
         wait_idle();
         send(8'h35, ok);
         expect_word(f8({t == 1 || t == 2, 7'h35}));
      end
      fmt <= '{1'b1, 1'b0, 2'h0, 1'b0, 1'b1, 1'b1};
      nbits <= 4'hc;
      wait_idle();
      send(8'h0f, ok);
      expect_word({2'h3, 9'h10f, 1'b0});
      fmt <= '0;
      nbits <= 4'hb;
      $display("test parity done");
      wait_idle();
      for (int k = 0; k < 5; k++)
      begin
         send(8'h81 + 8'(k), ok);
         if (ok === 1'b1)
            exp_q.push_back(8'h81 + 8'(k));
      end
      @(negedge mclk);
      check(16'(exp_q.size()), 16'h3, "refusal");
      check(16'(irq), 16'h0, "irq masked");
      while (exp_q.size() > 0)
         expect_word(f8(exp_q.pop_front()));
      $display("test buffer done");
      wait_idle();
      send(8'h00, ok);
      repeat (40) @(posedge mclk);
      ten <= 1'b0;
      repeat (2) @(negedge mclk);
      check({oe, pin}, 2'b01, "tx abort");
      repeat (300) @(posedge mclk);
      i_model.word_q.delete();
      ten <= 1'b1;
      send(8'h00, ok);
      send(8'h00, ok);
      repeat (40) @(posedge mclk);
      men <= 1'b0;
      repeat (2) @(negedge mclk);
      check({oe, pin, lin, emp, idl, ridl}, 6'b010111, "off");
      repeat (300) @(posedge mclk);
      i_model.word_q.delete();
      men <= 1'b1;
      repeat (400) @(posedge mclk);
      check(16'(i_model.word_q.size()), 16'h0, "flushed");
      send(8'h3c, ok);
      expect_word(f8(8'h3c));
      $display("test disable done");
      wait_idle();
      @(posedge mclk);
      i_model.len_q.delete();
      brk <= 1'b1;
      repeat (20 * DIV) @(posedge mclk);
      brk <= 1'b0;
      wait_idle();
      check(16'(i_model.len_q[1] >= 14 * DIV), 16'h1, "break");
      $display("test break done");
      tally_and_finish();
   end
endmodule : utxf_uart_tx_bench
